// ===== design/pmr_defs.svh
// constants for the program memory map and remap block
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// ************************************************************
// register map
// ************************************************************
`define PMR_CFG_OFS 12'h000
`define PMR_STAT_OFS 12'h004
`define PMR_CFG_VIS_BIT 7
`define PMR_CFG_RST 8'h00

// ************************************************************
// memory geometry
// ************************************************************
`define PMR_SEC_BASE 16'hF000
`define PMR_PRI_TOP_16K 16'h3FFF
`define PMR_PRI_TOP_32K 16'h7FFF
`define PMR_PRI_ROW_BYTES 64
`define PMR_SEC_ROW_BYTES 32
`define PMR_SEC_SECTORS 64
`define PMR_ROWS_PER_SECTOR 2

// ************************************************************
// timing
// ************************************************************
`define PMR_MC_CLOCKS 12
`define PMR_RST_MC 2
`define PMR_ALE_DIV 6

`endif

// ===== design/pmr_pkg.sv
// types for the program memory map and remap block
`default_nettype none
package pmr_pkg;
    typedef enum logic [1:0] {
        PMR_MAP_NONE = 2'b00,
        PMR_MAP_1K = 2'b01,
        PMR_MAP_2K = 2'b10,
        PMR_MAP_4K = 2'b11
    } pmr_map_t;

    typedef enum logic [1:0] {
        PMR_ST_RESET = 2'b00,
        PMR_ST_RUN = 2'b01,
        PMR_ST_HOST = 2'b10
    } pmr_state_t;

    typedef struct packed {
        logic valid;
        logic code;
        logic [15:0] addr;
    } pmr_req_t;

    typedef struct packed {
        logic internal;
        logic primary;
        logic secondary;
        logic [15:0] addr;
    } pmr_dec_t;
endpackage
`default_nettype wire

// ===== design/pmr_sync.sv
// two-stage synchroniser for pin levels
`default_nettype none
module pmr_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= '0;
            q <= '0;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule
`default_nettype wire

// ===== design/pmr_top.sv
// program space decoder with remap, reset/host entry and address strobe
`include "pmr_defs.svh"
`default_nettype none
module pmr_top #(
    parameter bit BIG_PRIMARY = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    // pins
    input wire logic reset_pin,
    input wire logic external_fetch_strap_n,
    input wire logic program_store_strobe_n,
    input wire logic [1:0] remap_nv_bits,
    input wire logic [2:0] lock_level,
    // core side
    input wire pmr_pkg::pmr_req_t req,
    input wire logic xdata_access,
    output pmr_pkg::pmr_dec_t dec,
    output logic core_reset,
    output logic host_mode,
    output logic ale,
    // axi4-lite
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pmr_pkg::*;

    localparam int RST_CLKS = `PMR_RST_MC * `PMR_MC_CLOCKS;
    localparam logic [15:0] PRI_TOP = BIG_PRIMARY ? `PMR_PRI_TOP_32K : `PMR_PRI_TOP_16K;
    // sector size in bytes, used here only to derive PRI_SECTORS
    localparam int PRI_SECTOR_BYTES = `PMR_ROWS_PER_SECTOR * `PMR_PRI_ROW_BYTES;
    localparam int PRI_SECTORS = (int'(PRI_TOP) + 1) / PRI_SECTOR_BYTES;
    localparam int SEC_SECTOR_BYTES = `PMR_ROWS_PER_SECTOR * `PMR_SEC_ROW_BYTES;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic rst_s, strap_n_s, pstrb_n_s, pstrb_s;

    pmr_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({reset_pin, external_fetch_strap_n, !program_store_strobe_n}),
        .q({rst_s, strap_n_s, pstrb_s})
    );
    assign pstrb_n_s = !pstrb_s; // inverted so the flops reset to idle, no false fall

    // ************************************************************
    // reset qualification and host entry
    // ************************************************************
    pmr_state_t state_r;
    logic [7:0] rst_cnt_r;
    logic pstrb_d_r;
    logic host_seen_r;
    logic strap_lat_r;
    logic [1:0] map_r;
    logic [7:0] cfg_hi_r;
    wire rst_long = rst_cnt_r >= 8'(RST_CLKS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt_r <= 8'h00;
        end else if (!rst_s) begin
            rst_cnt_r <= 8'h00;
        end else if (!rst_long) begin
            rst_cnt_r <= rst_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pstrb_d_r <= 1'b1;
        end else begin
            pstrb_d_r <= pstrb_n_s;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_seen_r <= 1'b0;
        end else if (!rst_s) begin
            host_seen_r <= 1'b0;
        end else if (pstrb_d_r && !pstrb_n_s) begin
            host_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= PMR_ST_RESET;
        end else begin
            case (state_r)
                PMR_ST_RESET: begin
                    if (!rst_s && rst_long) begin
                        state_r <= host_seen_r ? PMR_ST_HOST : PMR_ST_RUN;
                    end
                end
                PMR_ST_RUN, PMR_ST_HOST: begin
                    if (rst_long) begin
                        state_r <= PMR_ST_RESET;
                    end
                end
                default: state_r <= PMR_ST_RESET;
            endcase
        end
    end

    // rst_long holds one cycle past pin release, so leaving reset sees it
    wire in_reset = state_r == PMR_ST_RESET;
    assign core_reset = in_reset;
    assign host_mode = state_r == PMR_ST_HOST;

    // strap captured while reset is held; released value used afterwards at lock levels other than 2, 3 and 4
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_lat_r <= 1'b0;
        end else if (in_reset) begin
            strap_lat_r <= strap_n_s;
        end
    end

    // ************************************************************
    // internal/external execution select
    // ************************************************************
    logic internal_en;
    always_comb begin
        if (lock_level == 3'd4) begin
            internal_en = 1'b1;
        end else if (lock_level == 3'd2 || lock_level == 3'd3) begin
            internal_en = strap_n_s;
        end else begin
            internal_en = strap_lat_r;
        end
    end

    // ************************************************************
    // code space decode
    // ************************************************************
    pmr_map_t map;
    assign map = pmr_map_t'(map_r);
    logic [15:0] ov_mask;
    always_comb begin
        case (map)
            PMR_MAP_1K: ov_mask = 16'hFC00;
            PMR_MAP_2K: ov_mask = 16'hF800;
            PMR_MAP_4K: ov_mask = 16'hF000;
            default: ov_mask = 16'h0000;
        endcase
    end

    logic overlay_hit;
    logic [15:0] eff_addr;
    logic vis;
    assign vis = cfg_hi_r[`PMR_CFG_VIS_BIT];
    always_comb begin
        overlay_hit = req.code && map != PMR_MAP_NONE
            && (req.addr & ov_mask) == 16'h0000;
        // forcing top four bits lands the overlay in the secondary block
        eff_addr = overlay_hit ? (req.addr | 16'hF000) : req.addr;
    end

    pmr_dec_t dec_nxt;
    always_comb begin
        dec_nxt = '0;
        dec_nxt.addr = eff_addr;
        if (req.valid && !in_reset) begin
            if (req.code && internal_en) begin
                if (eff_addr >= `PMR_SEC_BASE) begin
                    dec_nxt.secondary = vis || overlay_hit;
                end else if (eff_addr <= PRI_TOP) begin
                    dec_nxt.primary = !overlay_hit;
                end
                dec_nxt.internal = dec_nxt.primary | dec_nxt.secondary;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dec <= '0;
        end else begin
            dec <= dec_nxt;
        end
    end

    // ************************************************************
    // address latch strobe
    // ************************************************************
    logic [2:0] ale_cnt_r;
    logic ale_skip_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || in_reset) begin
            ale_cnt_r <= 3'd0;
        end else if (ale_cnt_r == 3'(`PMR_ALE_DIV - 1)) begin
            ale_cnt_r <= 3'd0;
        end else begin
            ale_cnt_r <= ale_cnt_r + 3'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ale_skip_r <= 1'b0;
        end else if (xdata_access && ale_cnt_r != 3'd0) begin
            ale_skip_r <= 1'b1;
        end else if (ale_cnt_r == 3'd0) begin
            ale_skip_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ale <= 1'b0;
        end else begin
            ale <= !in_reset && ale_cnt_r == 3'd0 && !ale_skip_r && !xdata_access;
        end
    end

    // ************************************************************
    // register bus
    // ************************************************************
    logic aw_hold_r, w_hold_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire do_wr = aw_hold_r && w_hold_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_wr) begin
            w_hold_r <= 1'b0;
        end
    end

    wire cfg_wr = do_wr && aw_addr_r == `PMR_CFG_OFS && w_strb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == `PMR_CFG_OFS || aw_addr_r == `PMR_STAT_OFS)
                ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // remap field reloads from the inverted nv bits on every cycle the device is in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            map_r <= 2'b00;
        end else if (in_reset) begin
            map_r <= ~remap_nv_bits;
        end else if (cfg_wr) begin
            map_r <= w_data_r[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || in_reset) begin
            cfg_hi_r <= `PMR_CFG_RST;
        end else if (cfg_wr) begin
            cfg_hi_r <= {w_data_r[7:2], 2'b00};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            if (s_axi_araddr == `PMR_CFG_OFS) begin
                s_axi_rdata <= {24'h000000, cfg_hi_r[7:2], map_r};
            end else if (s_axi_araddr == `PMR_STAT_OFS) begin
                s_axi_rdata <= {27'h0000000, internal_en, host_mode, state_r, strap_lat_r};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence pin_held_s;
        rst_s [*8];
    endsequence

    reset_qual_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!in_reset && rst_s && rst_cnt_r == 8'(RST_CLKS - 1)) |-> ##2 in_reset)
        else $error("long reset pin did not reset device");
    host_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_reset && rst_long && !rst_s && host_seen_r) |=> host_mode)
        else $error("host mode not entered");
    lock_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (lock_level == 3'd4) |-> internal_en)
        else $error("lock level 4 allowed external fetch");
    ale_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ale |-> ##1 !ale [*5])
        else $error("address strobe faster than one in six");
    remap_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (req.valid && req.code && map == PMR_MAP_4K && req.addr < 16'h1000)
        |=> dec.addr[15:12] == 4'hF)
        else $error("4K overlay did not force top bits");
    overlay_hide_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (req.valid && overlay_hit) |=> !dec.primary)
        else $error("overlaid primary reached by fetch");
    vis_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (req.valid && !overlay_hit && !vis) |=> !dec.secondary)
        else $error("hidden secondary block answered fetch");
    data_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (req.valid && !req.code) |=> dec.addr == $past(req.addr))
        else $error("data address altered by remap");
    clear_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_wr && !in_reset && w_data_r[1:0] == 2'b00) |=> map_r == 2'b00)
        else $error("writing zero did not disable remap");
    nv_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_held_s ##0 in_reset) |=> map_r == ~$past(remap_nv_bits))
        else $error("remap field not loaded at reset");
endmodule
`default_nettype wire

// ===== tb/pmr_host.sv
// outside host model that drives the reset pin and the program strobe pin
`default_nettype none
module pmr_host (
    input wire logic aclk,
    input wire logic start,
    input wire logic host_entry,
    input wire logic [7:0] hold_len,
    output logic reset_pin,
    output logic program_store_strobe_n,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    // strobe pin idles at its pull-up level
    initial begin
        reset_pin = 1'b0;
        program_store_strobe_n = 1'b1;
        busy = 1'b0;
        cnt_r = 8'h00;
    end
    always @(posedge aclk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            cnt_r <= hold_len;
            reset_pin <= 1'b1;
        end else if (busy) begin
            cnt_r <= cnt_r - 8'h01;
            // fall lands mid-hold, well after the pin is seen high
            if (cnt_r == (hold_len >> 1) && host_entry) begin
                program_store_strobe_n <= 1'b0;
            end
            if (cnt_r == 8'h01) begin
                reset_pin <= 1'b0;
                busy <= 1'b0;
                program_store_strobe_n <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/pmr_top_tb.sv
// self-checking bench for the program space decoder
`include "pmr_defs.svh"
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pmr_top_tb;
    import pmr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic reset_pin, program_store_strobe_n, host_busy;
    logic start = 1'b0;
    logic host_entry = 1'b0;
    logic [7:0] hold_len = 8'h1E;
    logic external_fetch_strap_n = 1'b1;
    logic [1:0] remap_nv_bits = 2'b11;
    logic [2:0] lock_level = 3'h0;
    pmr_req_t req = '0;
    logic xdata_access = 1'b0;
    pmr_dec_t dec;
    logic core_reset, host_mode, ale;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] rd;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'hF799;
    int map_m = 0;
    int n, a;
    bit vis = 1'b0;
    bit ien = 1'b1;

    pmr_top u_pmr_top (.aclk, .aresetn, .reset_pin, .external_fetch_strap_n,
        .program_store_strobe_n, .remap_nv_bits, .lock_level, .req, .xdata_access, .dec,
        .core_reset, .host_mode, .ale, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    pmr_host u_host (.aclk, .start, .host_entry, .hold_len, .reset_pin,
        .program_store_strobe_n, .busy(host_busy));

    always #12.5 aclk = ~aclk;

    // ************************************************************
    // reference model and helpers
    // ************************************************************
    function automatic logic [18:0] exp_dec(int ad);
        int sz;
        int o;
        bit p;
        bit s;
        sz = (map_m == 0) ? 0 : (1024 << (map_m - 1));
        // only the low sixteen bits reach the decoder
        o = ad & 32'h0000_FFFF;
        p = 1'b0;
        s = 1'b0;
        if (ien && o < sz) begin
            o = o | `PMR_SEC_BASE;
            s = 1'b1;
        end else if (ien) begin
            p = o <= `PMR_PRI_TOP_32K;
            s = o >= `PMR_SEC_BASE && vis;
        end
        return {p || s, p, s, o[15:0]};
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic fetch(int ad, bit code);
        @(posedge aclk);
        req <= {1'b1, code, ad[15:0]};
        @(posedge aclk);
        req <= '0;
        @(negedge aclk);
        if (code) `CHK(dec, exp_dec(ad))
    endtask

    // handshake flags taken at the falling edge, acted on at the next rising one
    task automatic axi_wr(logic [11:0] ad, logic [31:0] d);
        bit at, wt, bt, fin;
        fin = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 40 && !fin; k++) begin
            @(negedge aclk);
            at = s_axi_awvalid && s_axi_awready;
            wt = s_axi_wvalid && s_axi_wready;
            bt = s_axi_bvalid;
            if (bt) resp = s_axi_bresp;
            @(posedge aclk);
            if (at) s_axi_awvalid <= 1'b0;
            if (wt) s_axi_wvalid <= 1'b0;
            if (bt) s_axi_bready <= 1'b0;
            fin = bt;
        end
        `CHK(fin, 1'b1)
    endtask

    task automatic axi_rd(logic [11:0] ad);
        bit at, fin;
        fin = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 40 && !fin; k++) begin
            @(negedge aclk);
            at = s_axi_arvalid && s_axi_arready;
            fin = s_axi_rvalid;
            if (fin) rd = s_axi_rdata;
            if (fin) resp = s_axi_rresp;
            @(posedge aclk);
            if (at) s_axi_arvalid <= 1'b0;
            if (fin) s_axi_rready <= 1'b0;
        end
        `CHK(fin, 1'b1)
    endtask

    task automatic set_cfg(int m, bit v);
        axi_wr(`PMR_CFG_OFS, {24'h000000, v, 5'h00, m[1:0]});
        map_m = m;
        vis = v;
        `CHK(resp, 2'b00)
    endtask

    task automatic dev_reset(bit h, logic [7:0] len);
        @(posedge aclk);
        host_entry <= h;
        hold_len <= len;
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        // busy only rises at this edge; look once it has settled
        @(negedge aclk);
        for (int k = 0; k < 300 && host_busy; k++) @(negedge aclk);
        // core reset falls three clocks after the pin
        repeat (8) @(posedge aclk);
        @(negedge aclk);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        dev_reset(1'b0, 8'h1E);
        `CHK(core_reset, 1'b0)
        `CHK(host_mode, 1'b0)
        set_cfg(2, 1'b0);
        dev_reset(1'b0, 8'h14);
        axi_rd(`PMR_CFG_OFS);
        `CHK(rd[1:0], 2'b10)
        `CHK(core_reset, 1'b0)
        $display("test reset length done");
        for (int nv = 3; nv >= 0; nv--) begin
            remap_nv_bits <= nv[1:0];
            dev_reset(1'b0, 8'h1E);
            map_m = 3 - nv;
            vis = 1'b0;
            axi_rd(`PMR_CFG_OFS);
            `CHK(rd[1:0], ~nv[1:0])
            a = (map_m == 0) ? 0 : (1024 << (map_m - 1));
            fetch(a - 1, 1'b1);
            fetch(a, 1'b1);
            fetch(0, 1'b1);
            remap_nv_bits <= ~nv[1:0];
            repeat (3) @(posedge aclk);
            axi_rd(`PMR_CFG_OFS);
            `CHK(rd[1:0], ~nv[1:0])
        end
        fetch(12'h123, 1'b0);
        `CHK(dec.addr, 16'h0123)
        set_cfg(0, 1'b0);
        fetch(12'hFFF, 1'b1);
        $display("test remap done");
        fetch(16'hF123, 1'b1);
        set_cfg(0, 1'b1);
        axi_rd(`PMR_CFG_OFS);
        `CHK(rd[7], 1'b1)
        fetch(16'hF123, 1'b1);
        fetch(16'h7FFF, 1'b1);
        fetch(16'h8000, 1'b1);
        for (int i = 0; i < 40; i++) begin
            if (i % 8 == 0) set_cfg($random(seed) & 3, $random(seed) & 1);
            fetch($random(seed) & 16'hFFFF, 1'b1);
        end
        $display("test visibility done");
        external_fetch_strap_n <= 1'b0;
        set_cfg(0, 1'b0);
        dev_reset(1'b0, 8'h1E);
        ien = 1'b0;
        fetch(16'h0100, 1'b1);
        lock_level <= 3'h4;
        ien = 1'b1;
        repeat (4) @(posedge aclk);
        fetch(16'h0100, 1'b1);
        lock_level <= 3'h2;
        ien = 1'b0;
        repeat (4) @(posedge aclk);
        fetch(16'h0100, 1'b1);
        external_fetch_strap_n <= 1'b1;
        ien = 1'b1;
        repeat (5) @(posedge aclk);
        fetch(16'h0100, 1'b1);
        lock_level <= 3'h0;
        ien = 1'b0;
        repeat (4) @(posedge aclk);
        fetch(16'h0100, 1'b1);
        $display("test fetch source done");
        dev_reset(1'b1, 8'h1E);
        `CHK(host_mode, 1'b1)
        dev_reset(1'b0, 8'h1E);
        `CHK(host_mode, 1'b0)
        `CHK(core_reset, 1'b0)
        $display("test host entry done");
        for (int x = 0; x < 2; x++) begin
            n = 0;
            @(posedge aclk);
            xdata_access <= x[0];
            @(posedge aclk);
            xdata_access <= 1'b0;
            repeat (60) begin
                @(negedge aclk);
                n += (ale === 1'b1);
            end
            `CHK(n, 10 - x)
        end
        $display("test address strobe done");
        axi_rd(12'h010);
        `CHK(resp, 2'b10)
        `CHK(rd, 32'h00000000)
        $display("test unmapped access done");
        summarize();
    end
endmodule
`default_nettype wire
